/* src/flash_cpu_reprog_ctrl.sv */
// Processor-driven flash reprogramming controller: control and command
// registers, program/erase sequencer, watchdog hold and array access.
// Assumes the CPU bus is synchronous to clk_in; the supply sense input
// is asynchronous and is synchronised here.
//
// Function
// - Mode needs select bit and high voltage
// - Read-only monitor flag shows active mode
// - Busy flag high only during program/erase
// - Area bits limit erase and program
// - Read code selects persistent read mode
// - Read mode after reset and reset command
// - Next byte write after program code programs
// - Busy set at program start, cleared after
// - Watchdog held at all ones while busy
// - Program verify reads stored data
// - Erase starts on two erase codes
// - Busy set at erase start, cleared after
// - Erase verify reads addressed location
// - Two reset codes cancel pending operation
// - Reset command leaves array unchanged
`timescale 1ns/100ps
`include "flash_reprog_params.svh"
module flash_cpu_reprog_ctrl #(
    parameter int unsigned PROG_CYCLES = `FRP_PROG_CYC,
    parameter int unsigned ERASE_CYCLES = `FRP_ERASE_CYC
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic high_prog_voltage_level_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_wdata_in,
    input wire logic flash_wr_in,
    input wire logic flash_rd_in,
    input wire logic [`FRP_ADDR_W-1:0] flash_addr_in,
    input wire logic [7:0] flash_wdata_in,
    output logic [7:0] ctrl_rdata_out,
    output logic [7:0] flash_rdata_out,
    output logic flash_rvalid_out,
    output logic busy_out,
    output logic wdt_hold_out,
    output logic [15:0] wdt_load_out
);

    // ------------------------------------------------------------
    // Supply sense
    // ------------------------------------------------------------
    logic vpp_ok; // Synchronised high-voltage level
    flash_sync2 u_vpp_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in(high_prog_voltage_level_in),
        .q_out(vpp_ok)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic mode_sel_r; // Software mode select
    logic [1:0] area_r; // Erase/program area select
    logic monitor_r; // Mode really in effect
    logic busy_r; // Program or erase running
    flash_reprog_pkg::seq_t seq_r;
    flash_reprog_pkg::mode_t mode_r;

    // Software fields; busy and monitor are not writable
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mode_sel_r <= 1'b0;
            area_r <= 2'h0;
        end else if (ctrl_wr_in) begin
            mode_sel_r <= ctrl_wdata_in[`FRP_MODE_SEL_BIT];
            area_r <= ctrl_wdata_in[`FRP_AREA_HI_BIT:`FRP_AREA_LO_BIT];
        end
    end

    // Mode valid only with both select and voltage
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            monitor_r <= 1'b0;
        end else begin
            monitor_r <= mode_sel_r & vpp_ok;
        end
    end

    // Busy follows the sequencer, never a write
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (seq_r != flash_reprog_pkg::SEQ_IDLE);
        end
    end

    // Read view of the control register; bits 3,6,7 read zero
    logic [7:0] ctrl_view;
    always_comb begin
        ctrl_view = `FRP_CTRL_RESET;
        ctrl_view[`FRP_MODE_SEL_BIT] = mode_sel_r;
        ctrl_view[`FRP_BUSY_BIT] = busy_r;
        ctrl_view[`FRP_MONITOR_BIT] = monitor_r;
        ctrl_view[`FRP_AREA_HI_BIT:`FRP_AREA_LO_BIT] = area_r;
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ctrl_rdata_out <= `FRP_CTRL_RESET;
        end else begin
            ctrl_rdata_out <= ctrl_view;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic reset_seen_r; // One reset code already taken
    logic erase_go; // Second erase code in a row
    logic prog_go; // Byte write in program mode
    logic [`FRP_ADDR_W-1:0] prog_addr_r;
    logic [7:0] prog_data_r;
    logic cmd_ok; // Commands only act in active mode
    logic idle;

    assign cmd_ok = cmd_wr_in & monitor_r;
    assign idle = (seq_r == flash_reprog_pkg::SEQ_IDLE);
    // Erase armed by the previous write, area known at this point
    assign erase_go = cmd_ok & idle & (mode_r == flash_reprog_pkg::MODE_ERASE_ARMED)
                      & (cmd_wdata_in == `FRP_CMD_ERASE);
    // Programming only lands inside the selected area
    assign prog_go = flash_wr_in & monitor_r & idle
                     & (mode_r == flash_reprog_pkg::MODE_PROGRAM)
                     & (flash_addr_in[`FRP_ADDR_W-1:`FRP_ADDR_W-2] == area_r);

    // Mode register; commands during busy are ignored to protect the array
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mode_r <= flash_reprog_pkg::MODE_READ;
            reset_seen_r <= 1'b0;
        end else if (!monitor_r) begin
            mode_r <= flash_reprog_pkg::MODE_READ;
            reset_seen_r <= 1'b0;
        end else if (cmd_ok && idle) begin
            reset_seen_r <= 1'b0;
            unique case (cmd_wdata_in)
                `FRP_CMD_READ: begin
                    mode_r <= flash_reprog_pkg::MODE_READ;
                end
                `FRP_CMD_PROGRAM: begin
                    mode_r <= flash_reprog_pkg::MODE_PROGRAM;
                end
                `FRP_CMD_PROG_VERIFY: begin
                    mode_r <= flash_reprog_pkg::MODE_PROG_VERIFY;
                end
                `FRP_CMD_ERASE: begin
                    // First code arms, second starts and returns to read
                    mode_r <= erase_go ? flash_reprog_pkg::MODE_READ
                                       : flash_reprog_pkg::MODE_ERASE_ARMED;
                end
                `FRP_CMD_ERASE_VERIFY: begin
                    mode_r <= flash_reprog_pkg::MODE_ERASE_VERIFY;
                end
                `FRP_CMD_RESET: begin
                    // Second reset code cancels; array is never touched
                    if (reset_seen_r) begin
                        mode_r <= flash_reprog_pkg::MODE_READ;
                    end else begin
                        mode_r <= flash_reprog_pkg::MODE_RESET;
                        reset_seen_r <= 1'b1;
                    end
                end
                default: begin
                    // Unknown code: drop any pending operation
                    mode_r <= flash_reprog_pkg::MODE_READ;
                end
            endcase
        end else if (prog_go) begin
            mode_r <= flash_reprog_pkg::MODE_READ;
        end
    end

    // Latch program target when programming starts
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            prog_addr_r <= '0;
            prog_data_r <= 8'h00;
        end else if (prog_go) begin
            prog_addr_r <= flash_addr_in;
            prog_data_r <= flash_wdata_in;
        end
    end

    // ------------------------------------------------------------
    // Program / erase sequencer
    // ------------------------------------------------------------
    logic [21:0] time_r; // Remaining operation cycles
    logic [7:0] erase_idx_r; // Byte index within the area
    localparam logic [21:0] PROG_LOAD = 22'(PROG_CYCLES - 1);
    localparam logic [21:0] ERASE_LOAD = 22'(ERASE_CYCLES - 1);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            seq_r <= flash_reprog_pkg::SEQ_IDLE;
            time_r <= 22'h0;
        end else begin
            unique case (seq_r)
                flash_reprog_pkg::SEQ_IDLE: begin
                    if (prog_go) begin
                        seq_r <= flash_reprog_pkg::SEQ_PROG;
                        time_r <= PROG_LOAD;
                    end else if (erase_go) begin
                        seq_r <= flash_reprog_pkg::SEQ_ERASE;
                        time_r <= ERASE_LOAD;
                    end
                end
                flash_reprog_pkg::SEQ_PROG, flash_reprog_pkg::SEQ_ERASE: begin
                    // Mode loss aborts; array write is one cycle so none is torn
                    if (time_r == 22'h0 || !monitor_r) begin
                        seq_r <= flash_reprog_pkg::SEQ_IDLE;
                    end else begin
                        time_r <= time_r - 22'h1;
                    end
                end
                default: begin
                    seq_r <= flash_reprog_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Erase walks the selected area one byte per cycle
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            erase_idx_r <= 8'h00;
        end else if (seq_r != flash_reprog_pkg::SEQ_ERASE) begin
            erase_idx_r <= 8'h00;
        end else if (erase_idx_r != 8'hFF) begin
            erase_idx_r <= erase_idx_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Array port
    // ------------------------------------------------------------
    logic mem_we;
    logic [`FRP_ADDR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic erase_wr_r; // Index 255 written once at the end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            erase_wr_r <= 1'b0;
        end else begin
            erase_wr_r <= (seq_r == flash_reprog_pkg::SEQ_ERASE) && (erase_idx_r != 8'hFF);
        end
    end

    always_comb begin
        mem_we = 1'b0;
        mem_waddr = prog_addr_r;
        mem_wdata = prog_data_r;
        if (seq_r == flash_reprog_pkg::SEQ_PROG && time_r == 22'h0 && monitor_r) begin
            mem_we = 1'b1;
        end else if (seq_r == flash_reprog_pkg::SEQ_ERASE
                     && (erase_idx_r != 8'hFF || erase_wr_r)) begin
            mem_we = 1'b1;
            mem_waddr = {area_r, erase_idx_r};
            mem_wdata = `FRP_ERASED_BYTE;
        end
    end

    flash_array_mem u_array (
        .clk_in(clk_in),
        .wr_en_in(mem_we),
        .wr_addr_in(mem_waddr),
        .wr_data_in(mem_wdata),
        .rd_addr_in(flash_addr_in),
        .rd_data_out(mem_rdata)
    );

    // Reads in any mode return stored bytes while the sequencer is idle
    logic rd_pend_r;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rd_pend_r <= 1'b0;
            flash_rvalid_out <= 1'b0;
        end else begin
            rd_pend_r <= flash_rd_in & idle;
            flash_rvalid_out <= rd_pend_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            flash_rdata_out <= 8'h00;
        end else if (rd_pend_r) begin
            flash_rdata_out <= mem_rdata;
        end
    end

    // ------------------------------------------------------------
    // Busy pin and watchdog hold
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            busy_out <= 1'b0;
            wdt_hold_out <= 1'b0;
            wdt_load_out <= 16'h0000;
        end else begin
            busy_out <= busy_r;
            wdt_hold_out <= busy_r;
            wdt_load_out <= busy_r ? `FRP_WDT_HOLD : 16'h0000;
        end
    end

endmodule : flash_cpu_reprog_ctrl

/* src/flash_reprog_params.svh */
// Constants of the processor-driven flash reprogramming controller.
// Assumes inclusion by bare name from any file of the controller.
`ifndef FLASH_REPROG_PARAMS_SVH
`define FLASH_REPROG_PARAMS_SVH

// Control register field positions
`define FRP_MODE_SEL_BIT 0
`define FRP_BUSY_BIT 1
`define FRP_MONITOR_BIT 2
`define FRP_AREA_LO_BIT 4
`define FRP_AREA_HI_BIT 5
// Control register reset value
`define FRP_CTRL_RESET 8'h00
// Command codes
`define FRP_CMD_READ 8'h00
`define FRP_CMD_PROGRAM 8'h40
`define FRP_CMD_PROG_VERIFY 8'hC0
`define FRP_CMD_ERASE 8'h20
`define FRP_CMD_ERASE_VERIFY 8'hA0
`define FRP_CMD_RESET 8'hFF
// Erased byte value and watchdog hold value
`define FRP_ERASED_BYTE 8'hFF
`define FRP_WDT_HOLD 16'hFFFF
// Array geometry: 4 areas of 256 bytes
`define FRP_ADDR_W 10
`define FRP_DEPTH 1024
// Operation times, in ns, and clock period
`define FRP_CLK_NS 5
`define FRP_PROG_NS 10000
`define FRP_ERASE_NS 9500000
`define FRP_PROG_CYC (`FRP_PROG_NS / `FRP_CLK_NS)
`define FRP_ERASE_CYC (`FRP_ERASE_NS / `FRP_CLK_NS)

`endif

/* src/flash_reprog_pkg.sv */
// Types shared by the flash reprogramming controller.
// Assumes nothing of its surroundings.
package flash_reprog_pkg;
    // Command modes held after a command write
    typedef enum logic [5:0] {
        MODE_READ = 6'h01,
        MODE_PROGRAM = 6'h02,
        MODE_PROG_VERIFY = 6'h04,
        MODE_ERASE_ARMED = 6'h08,
        MODE_ERASE_VERIFY = 6'h10,
        MODE_RESET = 6'h20
    } mode_t;
    // Array sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_PROG = 3'h2,
        SEQ_ERASE = 3'h4
    } seq_t;
endpackage : flash_reprog_pkg

/* src/flash_sync2.sv */
// Two flip-flop synchroniser for one level.
// Assumes the input comes from outside the clk_in domain.
`timescale 1ns/100ps
module flash_sync2 (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic d_in,
    output logic q_out
);
    // First stage is read only by the second
    logic meta_r;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : flash_sync2

/* src/flash_array_mem.sv */
// Byte-wide flash array model with registered read data.
// Assumes one write port and one read port on clk_in.
`timescale 1ns/100ps
`include "flash_reprog_params.svh"
module flash_array_mem (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [`FRP_ADDR_W-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [`FRP_ADDR_W-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    // Storage; content undefined until erased, like a fresh part
    logic [7:0] mem_r [0:`FRP_DEPTH-1];
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end
    // Registered read port
    always_ff @(posedge clk_in) begin
        rd_data_out <= mem_r[rd_addr_in];
    end
endmodule : flash_array_mem

/* dv/flash_ctrl_props.sv */
// Checker: concurrent properties on the controller's top-level ports.
// Assumes a single clock domain, synchronous reset, binding by name.
`timescale 1ns/100ps
`include "flash_reprog_params.svh"
module flash_ctrl_props #(
    parameter int unsigned PROG_CYCLES = `FRP_PROG_CYC,
    parameter int unsigned ERASE_CYCLES = `FRP_ERASE_CYC
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic high_prog_voltage_level_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_wdata_in,
    input wire logic flash_wr_in,
    input wire logic flash_rd_in,
    input wire logic [7:0] ctrl_rdata_out,
    input wire logic flash_rvalid_out,
    input wire logic busy_out,
    input wire logic wdt_hold_out,
    input wire logic [15:0] wdt_load_out
);
    // ----
    // Helper logic
    // ----
    logic start_req; // A strobe that may launch an operation
    logic [31:0] busy_cnt_r; // Cycles the busy bit has stood
    assign start_req = flash_wr_in || (cmd_wr_in && cmd_wdata_in == `FRP_CMD_ERASE);
    // Counter instead of a long repetition, which would unroll badly
    always_ff @(posedge clk_in) begin
        if (!rstn_in || !ctrl_rdata_out[1]) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ----
    // Properties
    // ----
    // Quiet bus with voltage present, so no pending change hides a read
    sequence s_rd_req;
        (high_prog_voltage_level_in && !flash_wr_in && !cmd_wr_in && !ctrl_wr_in) [*4]
        ##0 flash_rd_in && ctrl_rdata_out[2] && !ctrl_rdata_out[1] && !busy_out;
    endsequence
    property p_rd_answer;
        s_rd_req |-> ##2 flash_rvalid_out;
    endproperty
    property p_rv_cause;
        flash_rvalid_out |-> $past(flash_rd_in, 2);
    endproperty
    // Strobe edge, sequencer, busy bit, register view: three edges
    property p_busy_cause;
        $rose(ctrl_rdata_out[1]) |-> $past(start_req, 3);
    endproperty
    // Pin and register view are loaded from the busy bit at one edge
    property p_busy_copy;
        busy_out == ctrl_rdata_out[1];
    endproperty
    property p_wdt_tie;
        wdt_hold_out == busy_out;
    endproperty
    property p_wdt_val;
        wdt_hold_out |-> wdt_load_out == `FRP_WDT_HOLD;
    endproperty
    property p_busy_min;
        $fell(ctrl_rdata_out[1]) |-> $past(busy_cnt_r) >= PROG_CYCLES - 2;
    endproperty
    property p_busy_max;
        busy_cnt_r <= ERASE_CYCLES + 4;
    endproperty
    property p_echo;
        ctrl_wr_in |-> ##2 ctrl_rdata_out[0] == $past(ctrl_wdata_in[0], 2)
            && ctrl_rdata_out[5:4] == $past(ctrl_wdata_in[5:4], 2);
    endproperty
    property p_mon_rise;
        $rose(ctrl_rdata_out[2]) |-> ctrl_rdata_out[0];
    endproperty
    property p_mon_drop;
        !high_prog_voltage_level_in [*6] |-> !ctrl_rdata_out[2];
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
    a_busy_copy: assert property (p_busy_copy) else $error("busy pin differs");
    a_wdt_tie: assert property (p_wdt_tie) else $error("watchdog hold differs");
    a_wdt_val: assert property (p_wdt_val) else $error("watchdog load wrong");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    a_echo: assert property (p_echo) else $error("control write lost");
    a_mon_rise: assert property (p_mon_rise) else $error("monitor without select");
    a_mon_drop: assert property (p_mon_drop) else $error("monitor without voltage");
endmodule : flash_ctrl_props

bind flash_cpu_reprog_ctrl flash_ctrl_props #(
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) chk (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .high_prog_voltage_level_in(high_prog_voltage_level_in),
    .ctrl_wr_in(ctrl_wr_in), .ctrl_wdata_in(ctrl_wdata_in),
    .cmd_wr_in(cmd_wr_in), .cmd_wdata_in(cmd_wdata_in),
    .flash_wr_in(flash_wr_in), .flash_rd_in(flash_rd_in),
    .ctrl_rdata_out(ctrl_rdata_out), .flash_rvalid_out(flash_rvalid_out),
    .busy_out(busy_out), .wdt_hold_out(wdt_hold_out), .wdt_load_out(wdt_load_out)
);

/* dv/cpu_bus_model.sv */
// CPU-side model: control, command and flash strobes, one edge each.
// Assumes clk_in is the controller's clock; reads wait for rvalid.
`timescale 1ns/100ps
`include "flash_reprog_params.svh"
module cpu_bus_model (
    input wire logic clk_in,
    input wire logic rvalid_in,
    input wire logic [7:0] rdata_in,
    output logic [3:0] strobe_out,
    output logic [`FRP_ADDR_W-1:0] addr_out,
    output logic [7:0] data_out
);
    // ----
    // Bus cycles
    // ----
    // Idle bus at time zero
    initial begin
        strobe_out = 4'h0;
        addr_out = '0;
        data_out = 8'h00;
    end
    // Strobe held across one edge; idle data inverted, never a stale copy
    task automatic op(input logic [1:0] sel, input logic [`FRP_ADDR_W-1:0] a,
                      input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        data_out = d;
        strobe_out = 4'h1 << sel;
        @(posedge clk_in);
        #1;
        strobe_out = 4'h0;
        data_out = ~d;
    endtask : op
    // Read: unknown result if no answer within four edges
    task automatic rd(input logic [`FRP_ADDR_W-1:0] a, output logic [7:0] d);
        d = 8'hXX;
        op(2'h3, a, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            #1;
            if (rvalid_in === 1'b1) d = rdata_in;
        end
    endtask : rd
endmodule : cpu_bus_model

/* dv/flash_cpu_reprog_ctrl_bench.sv */
// Self-checking bench: CPU-side call sequences with expected values.
// Assumes the controller, its constants header, checker and CPU model.
`timescale 1ns/100ps
`include "flash_reprog_params.svh"
module flash_cpu_reprog_ctrl_bench;
    logic clk_in = 1'b0; // 200 MHz system clock
    logic rstn_in = 1'b0; // Sync reset, active low
    logic vpp = 1'b0; // Programming voltage present
    logic [3:0] stb; // Control, command, flash write, flash read
    logic [`FRP_ADDR_W-1:0] addr;
    logic [7:0] wdata, ctrl_rdata_out, flash_rdata_out, rd_v;
    logic flash_rvalid_out, busy_out, wdt_hold_out;
    logic [15:0] wdt_load_out;
    int n_fail = 0;
    int tests_run = 0;
    always #2.5 clk_in = ~clk_in;
    // Short operation times keep the run brief
    flash_cpu_reprog_ctrl #(.PROG_CYCLES(300), .ERASE_CYCLES(300)) uut (
        .clk_in(clk_in), .rstn_in(rstn_in), .high_prog_voltage_level_in(vpp),
        .ctrl_wr_in(stb[0]), .ctrl_wdata_in(wdata), .cmd_wr_in(stb[1]),
        .cmd_wdata_in(wdata), .flash_wr_in(stb[2]), .flash_rd_in(stb[3]),
        .flash_addr_in(addr), .flash_wdata_in(wdata), .ctrl_rdata_out(ctrl_rdata_out),
        .flash_rdata_out(flash_rdata_out), .flash_rvalid_out(flash_rvalid_out),
        .busy_out(busy_out), .wdt_hold_out(wdt_hold_out), .wdt_load_out(wdt_load_out));
    cpu_bus_model cpu (.clk_in(clk_in), .rvalid_in(flash_rvalid_out),
        .rdata_in(flash_rdata_out), .strobe_out(stb), .addr_out(addr), .data_out(wdata));
    // ----
    // Tasks
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle
    task automatic ctl(input logic [7:0] d, input logic [7:0] exp);
        cpu.op(2'h0, '0, d);
        settle(4);
        check(ctrl_rdata_out, exp);
    endtask : ctl
    task automatic cmd(input logic [7:0] d);
        cpu.op(2'h1, '0, d);
    endtask : cmd
    task automatic rd_chk(input logic [`FRP_ADDR_W-1:0] a, input logic [7:0] exp);
        cpu.rd(a, rd_v);
        check(rd_v, exp);
    endtask : rd_chk
    // Busy, watchdog hold and load agree; then bounded wait for the end
    task automatic busy_chk(input logic b);
        settle(3);
        check({7'h0, busy_out}, {7'h0, b});
        check({7'h0, wdt_hold_out}, {7'h0, b});
        check(wdt_load_out[15:8], {8{b}});
        check(wdt_load_out[7:0], {8{b}});
        check({7'h0, ctrl_rdata_out[1]}, {7'h0, b});
        for (int i = 0; i < 400 && busy_out === 1'b1; i++) begin
            settle(1);
        end
        settle(2);
        check({busy_out, ctrl_rdata_out[1], 6'h0}, 8'h00);
    endtask : busy_chk
    task automatic prog(input logic [`FRP_ADDR_W-1:0] a, input logic [7:0] d);
        cmd(`FRP_CMD_PROGRAM);
        cpu.op(2'h2, a, d);
        busy_chk(1'b1);
    endtask : prog
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // Hang guard, far beyond the few thousand cycles expected
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        summarize();
    end
    // ----
    // Sequence
    // ----
    initial begin
        settle(10);
        rstn_in = 1'b1;
        check(ctrl_rdata_out, `FRP_CTRL_RESET);
        ctl(8'h07, 8'h01);
        vpp = 1'b1;
        settle(6);
        check(ctrl_rdata_out, 8'h05);
        ctl(8'h00, 8'h00);
        ctl(8'h11, 8'h15);
        prog(10'h105, 8'h33);
        ctl(8'h01, 8'h05);
        prog(10'h005, 8'h5A);
        cmd(`FRP_CMD_PROG_VERIFY);
        rd_chk(10'h005, 8'h5A);
        cmd(`FRP_CMD_PROGRAM);
        cpu.op(2'h2, 10'h205, 8'h11);
        busy_chk(1'b0);
        cpu.op(2'h2, 10'h006, 8'h66);
        busy_chk(1'b1);
        cmd(`FRP_CMD_READ);
        rd_chk(10'h006, 8'h66);
        rd_chk(10'h005, 8'h5A);
        cmd(`FRP_CMD_PROGRAM);
        cmd(`FRP_CMD_RESET);
        cmd(`FRP_CMD_RESET);
        cpu.op(2'h2, 10'h007, 8'h00);
        busy_chk(1'b0);
        rd_chk(10'h005, 8'h5A);
        // Zero a byte of the area before its first erase
        prog(10'h0FF, 8'h00);
        cmd(`FRP_CMD_PROG_VERIFY);
        rd_chk(10'h0FF, 8'h00);
        cmd(`FRP_CMD_ERASE);
        cmd(`FRP_CMD_READ);
        cmd(`FRP_CMD_ERASE);
        busy_chk(1'b0);
        cmd(`FRP_CMD_ERASE);
        busy_chk(1'b1);
        cmd(`FRP_CMD_ERASE_VERIFY);
        rd_chk(10'h005, `FRP_ERASED_BYTE);
        rd_chk(10'h0FF, `FRP_ERASED_BYTE);
        rd_chk(10'h105, 8'h33);
        // Repeat erase straight after verify, with no zeroing pass
        cmd(`FRP_CMD_ERASE);
        cmd(`FRP_CMD_ERASE);
        busy_chk(1'b1);
        cmd(`FRP_CMD_ERASE_VERIFY);
        rd_chk(10'h000, `FRP_ERASED_BYTE);
        vpp = 1'b0;
        settle(6);
        check(ctrl_rdata_out, 8'h01);
        ctl(8'h00, 8'h00);
        rstn_in = 1'b0;
        settle(10);
        rstn_in = 1'b1;
        check(ctrl_rdata_out, `FRP_CTRL_RESET);
        summarize();
    end
endmodule : flash_cpu_reprog_ctrl_bench
